// file: bsx_consts.svh
// Purpose: constants for the branch, skip and bit execution unit
// Assumes: 8-bit data, status bits ordered C Z N V S H T I from bit 0
// Notes: cycle figures are clock counts per instruction
`ifndef BSX_CONSTS_SVH
`define BSX_CONSTS_SVH
`define FLAG_C 3'd0
`define FLAG_Z 3'd1
`define FLAG_N 3'd2
`define FLAG_V 3'd3
`define FLAG_S 3'd4
`define FLAG_H 3'd5
`define FLAG_T 3'd6
`define FLAG_I 3'd7
`define CYC_ONE 2'd1
`define CYC_TWO 2'd2
`define CYC_THREE 2'd3
`define STATUS_FLAGS_REGISTER_RST 8'h00
`endif

// file: bsx_pkg.sv
// Purpose: types for the branch, skip and bit execution unit
// Assumes: operation codes are chosen by the decoder in front of this unit
// Notes: none
package bsx_pkg;
    typedef enum logic [4:0] {
        OP_NONE,
        OP_CMP_IMM,
        OP_SKIP_REG_CLR,
        OP_SKIP_REG_SET,
        OP_SKIP_IO_CLR,
        OP_SKIP_IO_SET,
        OP_BR_FLAG_SET,
        OP_BR_FLAG_CLR,
        OP_BR_SIGNED_GE,
        OP_BR_SIGNED_LT,
        OP_IO_SET,
        OP_IO_CLR,
        OP_LSL,
        OP_LSR,
        OP_ROL,
        OP_ROR,
        OP_ASR,
        OP_SWAP,
        OP_FLAG_SET,
        OP_FLAG_CLR
    } op_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY
    } state_t;
endpackage

// file: branch_skip_bit_exec.sv
// Purpose: executes compare, skip, branch, io bit, shift and flag ops
// Assumes: op_valid_i is raised only while ready_o is high
// Notes: named branch forms other than signed ge/lt map onto flag set/clear ops with a fixed index
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "bsx_consts.svh"
module branch_skip_bit_exec #(
    parameter int PC_W = 13
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic op_valid_i,
    input wire bsx_pkg::op_t op_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic [7:0] reg_val_i,
    input wire logic [7:0] imm_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [6:0] offset_k_i,
    input wire logic next_is_long_i,
    input wire logic [4:0] io_addr_i,
    input wire logic [7:0] io_rdata_i,
    input wire logic [7:0] status_flags_register_wdata_i,
    input wire logic status_flags_register_we_i,
    output logic ready_o,
    output logic [PC_W-1:0] pc_next_o,
    output logic pc_load_o,
    output logic [7:0] result_o,
    output logic result_we_o,
    output logic [4:0] io_addr_o,
    output logic [7:0] io_wdata_o,
    output logic io_we_o,
    output logic [7:0] status_flags_register_o,
    output logic [1:0] cycles_o,
    output logic done_o
);
    // flags after a subtraction a - b
    function automatic logic [7:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                             input logic [7:0] s);
        logic [7:0] r;
        logic [7:0] d;
        r = s;
        d = a - b;
        r[`FLAG_C] = (~a[7] & b[7]) | (b[7] & d[7]) | (d[7] & ~a[7]);
        r[`FLAG_H] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
        r[`FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
        r[`FLAG_N] = d[7];
        r[`FLAG_Z] = (d == 8'h00);
        r[`FLAG_S] = d[7] ^ r[`FLAG_V];
        return r;
    endfunction

    // flags after a shift: new carry cy and result d
    function automatic logic [7:0] shf_flags(input logic [7:0] d, input logic cy,
                                             input logic [7:0] s);
        logic [7:0] r;
        r = s;
        r[`FLAG_C] = cy;
        r[`FLAG_Z] = (d == 8'h00);
        r[`FLAG_N] = d[7];
        r[`FLAG_V] = d[7] ^ cy;
        r[`FLAG_S] = cy;
        return r;
    endfunction

    bsx_pkg::state_t state_q; // idle or in a multi cycle op
    bsx_pkg::state_t state_d;
    logic [7:0] status_flags_register_q; // status flags register
    logic [7:0] status_flags_register_d;
    logic [1:0] left_q; // cycles still to run
    logic [1:0] left_d;
    logic [PC_W-1:0] pc_q; // latched next pc
    logic [PC_W-1:0] pc_d;
    logic load_q;
    logic load_d;
    logic [7:0] res_q;
    logic [7:0] res_d;
    logic res_we_q;
    logic res_we_d;
    logic [4:0] ioa_q;
    logic [4:0] ioa_d;
    logic [7:0] iow_q;
    logic [7:0] iow_d;
    logic iowe_q;
    logic iowe_d;
    logic [1:0] cyc_q;
    logic [1:0] cyc_d;
    logic done_q;
    logic done_d;

    wire logic c_in = status_flags_register_q[`FLAG_C];
    wire logic reg_bit = reg_val_i[bit_sel_i]; // selected register bit
    wire logic io_bit = io_rdata_i[bit_sel_i]; // selected io bit
    wire logic flag_bit = status_flags_register_q[bit_sel_i]; // selected status flag
    wire logic sgn_lt = status_flags_register_q[`FLAG_N] ^ status_flags_register_q[`FLAG_V];
    wire logic [7:0] bit_mask = 8'h01 << bit_sel_i;
    // relative target pc+k+1 with sign-extended k
    wire logic [PC_W-1:0] br_target = pc_i + PC_W'({{(PC_W-7){offset_k_i[6]}}, offset_k_i})
                                      + PC_W'(1);
    wire logic [PC_W-1:0] seq_pc = pc_i + PC_W'(1);
    // skip steps over one or two words
    wire logic [PC_W-1:0] skip_pc = next_is_long_i ? pc_i + PC_W'(3) : pc_i + PC_W'(2);
    wire logic [1:0] skip_cyc = next_is_long_i ? `CYC_THREE : `CYC_TWO;

    assign ready_o = (state_q == bsx_pkg::ST_IDLE);
    assign pc_next_o = pc_q;
    assign pc_load_o = load_q;
    assign result_o = res_q;
    assign result_we_o = res_we_q;
    assign io_addr_o = ioa_q;
    assign io_wdata_o = iow_q;
    assign io_we_o = iowe_q;
    assign status_flags_register_o = status_flags_register_q;
    assign cycles_o = cyc_q;
    assign done_o = done_q;

    // decode and execute; outputs register on the edge that accepts the op, done_o once the cycle count is spent
    always_comb begin
        logic take;
        take = 1'b0;
        state_d = state_q;
        status_flags_register_d = status_flags_register_we_i ? status_flags_register_wdata_i : status_flags_register_q;
        left_d = left_q;
        pc_d = pc_q;
        load_d = 1'b0;
        res_d = res_q;
        res_we_d = 1'b0;
        ioa_d = ioa_q;
        iow_d = iow_q;
        iowe_d = 1'b0;
        cyc_d = cyc_q;
        done_d = 1'b0;
        if (state_q == bsx_pkg::ST_BUSY) begin
            // hold off the next op until the cycle count is spent
            if (left_q <= 2'd1) begin
                state_d = bsx_pkg::ST_IDLE;
                done_d = 1'b1;
                left_d = 2'd0;
            end else begin
                left_d = left_q - 2'd1;
            end
        end else if (op_valid_i) begin
            cyc_d = `CYC_ONE;
            pc_d = seq_pc;
            case (op_i)
                bsx_pkg::OP_CMP_IMM: begin
                    status_flags_register_d = sub_flags(reg_val_i, imm_i, status_flags_register_q);
                end
                bsx_pkg::OP_SKIP_REG_CLR: take = ~reg_bit;
                bsx_pkg::OP_SKIP_REG_SET: take = reg_bit;
                bsx_pkg::OP_SKIP_IO_CLR: take = ~io_bit;
                bsx_pkg::OP_SKIP_IO_SET: take = io_bit;
                // covers zero, carry, unsigned, negative, t, h, v, i forms
                bsx_pkg::OP_BR_FLAG_SET: take = flag_bit;
                bsx_pkg::OP_BR_FLAG_CLR: take = ~flag_bit;
                bsx_pkg::OP_BR_SIGNED_GE: take = ~sgn_lt;
                bsx_pkg::OP_BR_SIGNED_LT: take = sgn_lt;
                bsx_pkg::OP_IO_SET, bsx_pkg::OP_IO_CLR: begin
                    // read-modify-write of one bit only, flags kept
                    ioa_d = io_addr_i;
                    iow_d = (op_i == bsx_pkg::OP_IO_SET) ? (io_rdata_i | bit_mask)
                                                         : (io_rdata_i & ~bit_mask);
                    iowe_d = 1'b1;
                    cyc_d = `CYC_TWO;
                end
                bsx_pkg::OP_LSL: begin
                    res_d = {reg_val_i[6:0], 1'b0};
                    status_flags_register_d = shf_flags({reg_val_i[6:0], 1'b0}, reg_val_i[7], status_flags_register_q);
                    res_we_d = 1'b1;
                end
                bsx_pkg::OP_LSR: begin
                    res_d = {1'b0, reg_val_i[7:1]};
                    status_flags_register_d = shf_flags({1'b0, reg_val_i[7:1]}, reg_val_i[0], status_flags_register_q);
                    res_we_d = 1'b1;
                end
                bsx_pkg::OP_ASR: begin
                    res_d = {reg_val_i[7], reg_val_i[7:1]};
                    status_flags_register_d = shf_flags({reg_val_i[7], reg_val_i[7:1]}, reg_val_i[0], status_flags_register_q);
                    res_we_d = 1'b1;
                end
                bsx_pkg::OP_ROL: begin
                    res_d = {reg_val_i[6:0], c_in};
                    status_flags_register_d = shf_flags({reg_val_i[6:0], c_in}, reg_val_i[7], status_flags_register_q);
                    res_we_d = 1'b1;
                end
                bsx_pkg::OP_ROR: begin
                    res_d = {c_in, reg_val_i[7:1]};
                    status_flags_register_d = shf_flags({c_in, reg_val_i[7:1]}, reg_val_i[0], status_flags_register_q);
                    res_we_d = 1'b1;
                end
                bsx_pkg::OP_SWAP: begin
                    res_d = {reg_val_i[3:0], reg_val_i[7:4]};
                    res_we_d = 1'b1;
                end
                bsx_pkg::OP_FLAG_SET: status_flags_register_d = status_flags_register_q | bit_mask;
                bsx_pkg::OP_FLAG_CLR: status_flags_register_d = status_flags_register_q & ~bit_mask;
                default: ;
            endcase
            // resolve skip or branch target and cost
            case (op_i)
                bsx_pkg::OP_SKIP_REG_CLR, bsx_pkg::OP_SKIP_REG_SET,
                bsx_pkg::OP_SKIP_IO_CLR, bsx_pkg::OP_SKIP_IO_SET: begin
                    if (take) begin
                        pc_d = skip_pc;
                        cyc_d = skip_cyc;
                    end
                end
                bsx_pkg::OP_BR_FLAG_SET, bsx_pkg::OP_BR_FLAG_CLR,
                bsx_pkg::OP_BR_SIGNED_GE, bsx_pkg::OP_BR_SIGNED_LT: begin
                    if (take) begin
                        pc_d = br_target;
                        cyc_d = `CYC_TWO;
                    end
                end
                default: ;
            endcase
            load_d = (op_i != bsx_pkg::OP_NONE);
            if (cyc_d == `CYC_ONE) begin
                done_d = 1'b1;
            end else begin
                state_d = bsx_pkg::ST_BUSY;
                left_d = cyc_d - 2'd1;
            end
        end
    end

    // state and output registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= bsx_pkg::ST_IDLE;
            status_flags_register_q <= `STATUS_FLAGS_REGISTER_RST;
            left_q <= 2'd0;
            pc_q <= '0;
            load_q <= 1'b0;
            res_q <= 8'h00;
            res_we_q <= 1'b0;
            ioa_q <= 5'h00;
            iow_q <= 8'h00;
            iowe_q <= 1'b0;
            cyc_q <= 2'd0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            status_flags_register_q <= status_flags_register_d;
            left_q <= left_d;
            pc_q <= pc_d;
            load_q <= load_d;
            res_q <= res_d;
            res_we_q <= res_we_d;
            ioa_q <= ioa_d;
            iow_q <= iow_d;
            iowe_q <= iowe_d;
            cyc_q <= cyc_d;
            done_q <= done_d;
        end
    end
endmodule

// file: branch_skip_bit_exec_chk.sv
// Purpose: port checker for the branch, skip and bit unit
// Assumes: requests are accepted only while ready_o is high
// Notes: status bits c z n v s h t i from bit 0
`timescale 1ns/10ps
module branch_skip_bit_exec_chk #(
    parameter int PC_W = 13
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic op_valid_i,
    input wire bsx_pkg::op_t op_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic [7:0] reg_val_i,
    input wire logic [7:0] imm_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [6:0] offset_k_i,
    input wire logic next_is_long_i,
    input wire logic [4:0] io_addr_i,
    input wire logic [7:0] io_rdata_i,
    input wire logic [7:0] status_flags_register_wdata_i,
    input wire logic status_flags_register_we_i,
    input wire logic ready_o,
    input wire logic [PC_W-1:0] pc_next_o,
    input wire logic pc_load_o,
    input wire logic [7:0] result_o,
    input wire logic result_we_o,
    input wire logic [4:0] io_addr_o,
    input wire logic [7:0] io_wdata_o,
    input wire logic io_we_o,
    input wire logic [7:0] status_flags_register_o,
    input wire logic [1:0] cycles_o,
    input wire logic done_o
);
    // request taken at this edge
    wire logic ac = op_valid_i && ready_o;
    // relative target, bit mask, skip target and rotate result
    wire logic [PC_W-1:0] tgt = pc_i + PC_W'($signed(offset_k_i)) + 1'b1;
    wire logic [PC_W-1:0] sk3 = pc_i + PC_W'(3);
    wire logic [7:0] bm = 8'h01 << bit_sel_i;
    wire logic [7:0] rl = {reg_val_i[6:0], status_flags_register_o[0]};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_cmp; ac && op_i == bsx_pkg::OP_CMP_IMM
        |=> !result_we_o && done_o && cycles_o == 2'h1; endproperty
    a_cmp: assert property (p_cmp) else $error("compare wrote back");
    property p_skip; ac && op_i == bsx_pkg::OP_SKIP_REG_SET && reg_val_i[bit_sel_i] && next_is_long_i
        |=> pc_load_o && pc_next_o == $past(sk3) && cycles_o == 2'h3 ##2 done_o; endproperty
    a_skip: assert property (p_skip) else $error("long skip wrong");
    property p_br; ac && op_i == bsx_pkg::OP_BR_FLAG_SET && status_flags_register_o[bit_sel_i]
        |=> pc_load_o && pc_next_o == $past(tgt) && cycles_o == 2'h2; endproperty
    a_br: assert property (p_br) else $error("branch not taken");
    property p_sge; ac && op_i == bsx_pkg::OP_BR_SIGNED_GE && !(status_flags_register_o[2] ^ status_flags_register_o[3])
        |=> pc_load_o && pc_next_o == $past(tgt); endproperty
    a_sge: assert property (p_sge) else $error("signed branch wrong");
    property p_ioset; ac && op_i == bsx_pkg::OP_IO_SET |=> io_we_o &&
        io_addr_o == $past(io_addr_i) && io_wdata_o == ($past(io_rdata_i) | $past(bm)); endproperty
    a_ioset: assert property (p_ioset) else $error("io bit set wrong");
    property p_io2; io_we_o |-> cycles_o == 2'h2 && !ready_o ##1 done_o && ready_o; endproperty
    a_io2: assert property (p_io2) else $error("io op not two cycles");
    property p_rol; ac && op_i == bsx_pkg::OP_ROL
        |=> result_o == $past(rl) && status_flags_register_o[0] == $past(reg_val_i[7]); endproperty
    a_rol: assert property (p_rol) else $error("rotate left wrong");
    property p_fset; ac && op_i == bsx_pkg::OP_FLAG_SET
        |=> status_flags_register_o == ($past(status_flags_register_o) | $past(bm)) && done_o; endproperty
    a_fset: assert property (p_fset) else $error("flag set wrong");
    // main scenarios reached
    c_skip: cover property (pc_load_o && cycles_o == 2'h3);
    c_io: cover property (io_we_o);
    c_br: cover property (pc_load_o && cycles_o == 2'h2);
endmodule
bind branch_skip_bit_exec branch_skip_bit_exec_chk #(.PC_W(PC_W)) chk_i (.clk_i(clk_i),
    .nrst_i(nrst_i), .op_valid_i(op_valid_i), .op_i(op_i), .pc_i(pc_i), .reg_val_i(reg_val_i),
    .imm_i(imm_i), .bit_sel_i(bit_sel_i), .offset_k_i(offset_k_i), .io_addr_i(io_addr_i),
    .next_is_long_i(next_is_long_i), .io_rdata_i(io_rdata_i), .status_flags_register_wdata_i(status_flags_register_wdata_i),
    .status_flags_register_we_i(status_flags_register_we_i), .ready_o(ready_o), .pc_next_o(pc_next_o), .pc_load_o(pc_load_o),
    .result_o(result_o), .result_we_o(result_we_o), .io_addr_o(io_addr_o), .io_we_o(io_we_o),
    .io_wdata_o(io_wdata_o), .status_flags_register_o(status_flags_register_o), .cycles_o(cycles_o), .done_o(done_o));

// file: tb_top.sv
// Purpose: random op stream checked against a bench model
// Assumes: one op in flight, next op once ready_o is high
// Notes: pc_next_o is compared whenever pc_load_o pulses
`timescale 1ns/10ps
module tb_top;
    localparam int PW = 13;
    logic clk_i = 1'b0, nrst_i = 1'b0, op_valid_i = 1'b0, next_is_long_i = 1'b0, status_flags_register_we_i = 1'b0;
    bsx_pkg::op_t op_i = bsx_pkg::OP_NONE;
    logic [PW-1:0] pc_i = 13'h0000;
    logic [7:0] reg_val_i = 8'h00, imm_i = 8'h00, io_rdata_i = 8'h00, status_flags_register_wdata_i = 8'h00;
    logic [2:0] bit_sel_i = 3'h0;
    logic [6:0] offset_k_i = 7'h00;
    logic [4:0] io_addr_i = 5'h00, io_addr_o;
    logic ready_o, pc_load_o, result_we_o, io_we_o, done_o, fix;
    logic [PW-1:0] pc_next_o;
    logic [7:0] result_o, io_wdata_o, status_flags_register_o, sm;
    logic [1:0] cycles_o;
    int mismatches = 0, n_checks = 0, tick = 0;
    // free running core clock
    always #2.5 clk_i = ~clk_i;
    branch_skip_bit_exec #(.PC_W(PW)) branch_skip_bit_exec_i (.clk_i(clk_i), .nrst_i(nrst_i),
        .op_valid_i(op_valid_i), .op_i(op_i), .pc_i(pc_i), .reg_val_i(reg_val_i), .imm_i(imm_i),
        .bit_sel_i(bit_sel_i), .offset_k_i(offset_k_i), .next_is_long_i(next_is_long_i),
        .io_addr_i(io_addr_i), .io_rdata_i(io_rdata_i), .status_flags_register_wdata_i(status_flags_register_wdata_i),
        .status_flags_register_we_i(status_flags_register_we_i), .ready_o(ready_o), .pc_next_o(pc_next_o), .pc_load_o(pc_load_o),
        .result_o(result_o), .result_we_o(result_we_o), .io_addr_o(io_addr_o),
        .io_wdata_o(io_wdata_o), .io_we_o(io_we_o), .status_flags_register_o(status_flags_register_o), .cycles_o(cycles_o),
        .done_o(done_o));
    // compare one value and count it
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task summarize();
        if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        tick <= tick + 1;
        if (tick == 20000) begin
            mismatches++;
            summarize();
        end
    end
    // load the status flags from outside
    task set_flags(input logic [7:0] v);
        @(posedge clk_i);
        status_flags_register_we_i <= 1'b1;
        status_flags_register_wdata_i <= v;
        @(posedge clk_i);
        status_flags_register_we_i <= 1'b0;
        #1 chk("status_flags_register_wr", status_flags_register_o, v);
        sm = v;
        fix = 1'b0;
    endtask
    // issue one op with random operands and check every result except the S flag after a compare
    task automatic run(input bsx_pkg::op_t op);
        logic [31:0] v, u;
        logic [7:0] r, im, io, d, s, m, w;
        logic [PW-1:0] np;
        logic t, rw, iw, sh;
        int c;
        v = $urandom;
        u = $urandom;
        {r, im, io} = v[23:0];
        s = sm;
        m = 8'hff;
        {t, sh, c, d, w} = {2'b00, 32'd1, 8'h00, io};
        np = u[19:7] + 13'h0001;
        case (op)
            bsx_pkg::OP_CMP_IMM: begin
                d = r - im;
                s[3:0] = {r[7] & ~im[7] & ~d[7] | ~r[7] & im[7] & d[7], d[7], d == 8'h00,
                    ~r[7] & im[7] | im[7] & d[7] | d[7] & ~r[7]};
                s[5] = ~r[3] & im[3] | im[3] & d[3] | d[3] & ~r[3];
                m = 8'hef;
            end
            bsx_pkg::OP_SKIP_REG_CLR: t = !r[v[26:24]];
            bsx_pkg::OP_SKIP_REG_SET: t = r[v[26:24]];
            bsx_pkg::OP_SKIP_IO_CLR: t = !io[v[26:24]];
            bsx_pkg::OP_SKIP_IO_SET: t = io[v[26:24]];
            bsx_pkg::OP_BR_FLAG_SET: t = s[v[26:24]];
            bsx_pkg::OP_BR_FLAG_CLR: t = !s[v[26:24]];
            bsx_pkg::OP_BR_SIGNED_GE: t = !(s[2] ^ s[3]);
            bsx_pkg::OP_BR_SIGNED_LT: t = s[2] ^ s[3];
            bsx_pkg::OP_IO_SET: w = io | (8'h01 << v[26:24]);
            bsx_pkg::OP_IO_CLR: w = io & ~(8'h01 << v[26:24]);
            bsx_pkg::OP_LSL: {sh, s[0], d} = {1'b1, r, 1'b0};
            bsx_pkg::OP_LSR: {sh, d, s[0]} = {2'b10, r};
            bsx_pkg::OP_ASR: {sh, d, s[0]} = {1'b1, r[7], r};
            bsx_pkg::OP_ROL: {sh, s[0], d} = {1'b1, r, s[0]};
            bsx_pkg::OP_ROR: {sh, d, s[0]} = {1'b1, s[0], r};
            bsx_pkg::OP_SWAP: d = {r[3:0], r[7:4]};
            bsx_pkg::OP_FLAG_SET: s[v[26:24]] = 1'b1;
            bsx_pkg::OP_FLAG_CLR: s[v[26:24]] = 1'b0;
            default: c = 1;
        endcase
        if (sh) s[4:1] = {d[7] ^ (d[7] ^ s[0]), d[7] ^ s[0], d[7], d == 8'h00};
        rw = sh || op == bsx_pkg::OP_SWAP;
        iw = op == bsx_pkg::OP_IO_SET || op == bsx_pkg::OP_IO_CLR;
        if (iw) c = 2;
        if (t && op <= bsx_pkg::OP_SKIP_IO_SET) {c, np} = {32'd2 + v[27], u[19:7] + 13'h2 + v[27]};
        if (t && op >= bsx_pkg::OP_BR_FLAG_SET) {c, np} = {32'd2, u[19:7] + 13'($signed(u[6:0])) + 13'h1};
        // drive on the rising edge, fields laid out as the model reads them
        @(posedge clk_i);
        {op_valid_i, op_i, reg_val_i, imm_i, io_rdata_i} <= {1'b1, op, r, im, io};
        {bit_sel_i, next_is_long_i, offset_k_i, pc_i} <= {v[26:24], v[27], u[6:0], u[19:7]};
        io_addr_i <= v[31:27];
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        #1 chk("pc_load", pc_load_o, op != bsx_pkg::OP_NONE);
        if (op != bsx_pkg::OP_NONE) chk("pc_next", pc_next_o, np);
        chk("result_we", result_we_o, rw);
        if (rw) chk("result", result_o, d);
        chk("io_we", io_we_o, iw);
        if (iw) chk("io_wdata", io_wdata_o, w);
        if (iw) chk("io_addr", io_addr_o, v[31:27]);
        chk("status_flags_register", status_flags_register_o & m, s & m);
        if (op != bsx_pkg::OP_NONE) begin
            chk("cycles", cycles_o, c);
            repeat (c - 1) begin
                chk("done_early", done_o, 1'b0);
                chk("busy", ready_o, 1'b0);
                @(posedge clk_i);
                #1;
            end
            chk("done", done_o, 1'b1);
            chk("ready", ready_o, 1'b1);
        end
        sm = s;
        fix = m != 8'hff;
    endtask
    // reset, then a long random stream, each op driven on a rising edge
    initial begin
        void'($urandom(62394));
        fix = 1'b0;
        sm = 8'h00;
        repeat (12) @(posedge clk_i);
        chk("rst_ready", ready_o, 1'b1);
        chk("rst_status_flags_register", status_flags_register_o, 8'h00);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        for (int i = 0; i < 800; i++) begin
            if (fix || $urandom % 3 == 0) set_flags(8'($urandom));
            run(bsx_pkg::op_t'(5'($urandom % 20)));
        end
        summarize();
    end
endmodule
